// ===== verif/card_interface_host_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module card_interface_host_port_bench;
  localparam int LIMIT = 80000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] sel = 3'h0;
  logic cardPresent = 1'b0;
  logic supplyFault = 1'b0;
  logic protFault = 1'b0;
  logic cardDrive = 1'b1;
  logic hostDrive = 1'b1;
  wire scl, sdaDrive, sdaOut, sdaOeB, cardIoOut, cardIoOeB, hostOut, hostOeB;
  wire cardVccOn, cardVcc3v, cardRst, cardClk, intB;
  // open-drain lines with pull-ups
  wire sdaLine = sdaDrive & (sdaOeB | sdaOut);
  wire cardIo = cardDrive & (cardIoOeB | cardIoOut);
  wire hostIo = hostDrive & (hostOeB | hostOut);
  int failures = 0;
  int testsRun = 0;
  int cycles = 0;
  host_master host_master_i (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaDrive(sdaDrive));
  card_interface_host_port #(.MUTE_CYC(60), .EARLY_CYC(10), .RST_LOW_CYC(40))
    card_interface_host_port_i (.clk(clk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOeB(sdaOeB), .addrSelectPins(sel), .cardPresent(cardPresent),
    .supplyFault(supplyFault), .protFault(protFault), .cardIoIn(cardIo),
    .cardIoOut(cardIoOut), .cardIoOeB(cardIoOeB), .hostSideDataLineIn(hostIo),
    .hostSideDataLineOut(hostOut), .hostSideDataLineOeB(hostOeB), .cardVccOn(cardVccOn),
    .cardVcc3v(cardVcc3v), .cardRst(cardRst), .cardClk(cardClk), .intB(intB));
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] q;
    logic a1, a2;
    host_master_i.frame({4'h4, sel, 1'b0}, d, q, a1, a2);
    check("write acks", 8'h00, {6'h0, a1, a2});
  endtask
  task automatic rd(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    logic a1, a2;
    host_master_i.frame({4'h4, sel, 1'b1}, 8'hff, q, a1, a2);
    check("read ack", 8'h00, {7'h0, a1});
    check("status", e, q & m);
  endtask
  task automatic wait_rst;
    int n;
    n = 0;
    while (cardRst !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    check("card reset release", 8'h01, {7'h0, cardRst});
  endtask
  task automatic addr_scan;
    logic [7:0] q;
    logic a1, a2;
    check("idle outputs", 8'h03, {4'h0, cardVccOn, cardVcc3v, hostOeB, intB});
    for (int s = 0; s < 8; s++)
    begin
      sel = s[2:0];
      rd(8'hff, 8'h04);
      host_master_i.frame({4'h4, sel ^ 3'h1, 1'b1}, 8'hff, q, a1, a2);
      check("foreign address ack", 8'h01, {7'h0, a1});
    end
  endtask
  task automatic presence_irq;
    cardPresent = 1'b1;
    wait_clk(10);
    check("irq on insert", 8'h00, {7'h0, intB});
    rd(8'hfb, 8'h03);
    rd(8'hfb, 8'h01);
    check("irq after read", 8'h01, {7'h0, intB});
    supplyFault = 1'b1;
    wait_clk(10);
    supplyFault = 1'b0;
    rd(8'hfb, 8'h09);
    rd(8'hfb, 8'h01);
  endtask
  task automatic session_early;
    wr(8'h05);
    check("supply on 3v", 8'h03, {6'h0, cardVccOn, cardVcc3v});
    wait_rst();
    wait_clk(20);
    // answer inside 10 card clocks
    cardDrive = 1'b0;
    wait_clk(20);
    check("no relay", 8'h01, {7'h0, hostOeB});
    rd(8'hff, 8'hc1);
    cardDrive = 1'b1;
    rd(8'hff, 8'hc5);
  endtask
  task automatic relay_both;
    wr(8'h85);
    cardDrive = 1'b0;
    wait_clk(8);
    check("relay to host", 8'h00, {7'h0, hostOeB});
    cardDrive = 1'b1;
    wait_clk(8);
    hostDrive = 1'b0;
    wait_clk(8);
    check("relay to card", 8'h00, {7'h0, cardIoOeB});
    hostDrive = 1'b1;
    wait_clk(8);
  endtask
  task automatic clock_rates;
    realtime t0;
    for (int r = 0; r < 4; r++)
    begin
      wr({1'b0, r[1:0], 5'h05});
      @(posedge cardClk);
      @(posedge cardClk);
      t0 = $realtime;
      @(posedge cardClk);
      check("card clock period", 8'h08 >> r, 8'(int'(($realtime - t0) / 50.0)));
    end
    wr(8'h0d);
    wait_clk(20);
    check("stopped low", 8'h00, {7'h0, cardClk});
    wr(8'h1d);
    wait_clk(20);
    check("stopped high", 8'h01, {7'h0, cardClk});
  endtask
  task automatic warm_and_stop;
    wr(8'h07);
    wait_clk(4);
    check("warm reset low", 8'h00, {7'h0, cardRst});
    wait_rst();
    // bit 2 kept while the 3 V session is shut down
    wr(8'h04);
    wait_clk(250);
    check("supply off", 8'h00, {7'h0, cardVccOn});
    rd(8'hd8, 8'h40);
  endtask
  task automatic mute_and_faults;
    wr(8'h05);
    wait_rst();
    wait_clk(600);
    rd(8'hf8, 8'ha0);
    protFault = 1'b1;
    wait_clk(10);
    check("irq on protection", 8'h00, {7'h0, intB});
    protFault = 1'b0;
    wait_clk(250);
    rd(8'hf8, 8'h30);
    wr(8'h04);
    wr(8'h01);
    wait_rst();
    cardPresent = 1'b0;
    wait_clk(250);
    check("removal shutdown", 8'h00, {6'h0, cardVccOn, cardRst});
    rd(8'hfb, 8'h02);
  endtask
  initial
  begin
    wait_clk(3);
    rst_b = 1'b1;
    wait_clk(5);
    addr_scan();
    presence_irq();
    session_early();
    relay_both();
    clock_rates();
    warm_and_stop();
    mute_and_faults();
    give_verdict();
  end
endmodule // card_interface_host_port_bench
bind card_interface_host_port card_port_checker card_port_checker_i (.clk(clk),
  .rst_b(rst_b), .sclIn(sclIn), .sdaOeB(sdaOeB), .cardPresent(cardPresent),
  .supplyFault(supplyFault), .cardVccOn(cardVccOn), .cardRst(cardRst), .intB(intB),
  .hostSideDataLineOeB(hostSideDataLineOeB));
`default_nettype wire

// ===== verif/card_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module card_port_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaOeB,
  input wire logic cardPresent,
  input wire logic supplyFault,
  input wire logic cardVccOn,
  input wire logic cardRst,
  input wire logic intB,
  input wire logic hostSideDataLineOeB
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ack_in_low_a:
    assert property ($fell(sdaOeB) |-> !sclIn)
    else $error("data pulled low while serial clock high");
  reset_needs_vcc_a:
    assert property (cardRst |-> cardVccOn)
    else $error("card reset high without supply");
  start_needs_card_a:
    assert property ($rose(cardVccOn) |-> cardPresent && !supplyFault)
    else $error("supply raised without card or with fault");
  removal_shutdown_a:
    assert property ($fell(cardPresent) && cardVccOn |-> ##[1:5] !cardRst ##[1:215] !cardVccOn)
    else $error("removal did not shut the card down");
  presence_irq_a:
    assert property ($changed(cardPresent) |-> ##[1:5] !intB)
    else $error("presence change without interrupt");
  supply_irq_a:
    assert property ($rose(supplyFault) |-> ##[1:5] !intB)
    else $error("supply fault without interrupt");
  irq_read_clear_a:
    assert property ($rose(intB) |-> !sclIn)
    else $error("interrupt released outside a status read");
  relay_active_a:
    assert property (!hostSideDataLineOeB |-> cardVccOn)
    else $error("host data line driven outside a session");
  cover property ($fell(cardPresent) && cardVccOn);
  cover property ($rose(cardRst));
  cover property ($rose(intB));
endmodule // card_port_checker
`default_nettype wire

// ===== verif/host_master.sv
`timescale 1ns/1ps
`default_nettype none
module host_master (
  input wire logic clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaDrive
);
  // 1.5 us half period keeps the bus below 400 kHz
  localparam int HALF = 30;
  initial
  begin
    scl = 1'b1;
    sdaDrive = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bitCycle(input logic b, output logic r);
    // data moves only once the clock fall has passed the synchroniser
    hold(2);
    sdaDrive = b;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    r = sdaLine;
    scl = 1'b0;
  endtask
  task automatic xferByte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitCycle(d[i], q[i]);
    bitCycle(1'b1, ack);
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic ackA, output logic ackD);
    logic [7:0] unused;
    hold(2);
    scl = 1'b1;
    hold(HALF);
    sdaDrive = 1'b0;
    hold(HALF);
    scl = 1'b0;
    xferByte(a, unused, ackA);
    ackD = 1'b1;
    if (ackA === 1'b0)
      xferByte(d, q, ackD);
    hold(2);
    sdaDrive = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sdaDrive = 1'b1;
    hold(HALF);
  endtask
endmodule // host_master
`default_nettype wire

// ===== verilog/card_clk_gen.v
`timescale 1ns/1ps
`default_nettype none

// card clock from the input clock: /8, /4, /2 or straight through
module card_clk_gen (
  input wire clk,
  input wire rst_b,
  input wire run,
  input wire stop,
  input wire stopHigh,
  input wire [1:0] rate,
  output wire cardClk,
  output reg tick
);

  reg [2:0] cnt_q;
  reg clkOut_q;
  wire advance;
  wire [2:0] cntNext;
  reg selNow;
  reg selNext;

  assign advance = run & ~stop;
  assign cntNext = cnt_q + 3'h1;

  always @*
  begin
    case (rate)
      2'b00:
      begin
        selNow = cnt_q[2];
        selNext = cntNext[2];
      end
      2'b01:
      begin
        selNow = cnt_q[1];
        selNext = cntNext[1];
      end
      2'b10:
      begin
        selNow = cnt_q[0];
        selNext = cntNext[0];
      end
      default:
      begin
        selNow = 1'b0;
        selNext = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 3'h0;
      clkOut_q <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= advance & selNext & ~selNow;
      if (advance)
      begin
        cnt_q <= cntNext;
        clkOut_q <= selNext;
      end
      else if (!run)
      begin
        cnt_q <= 3'h0;
        clkOut_q <= 1'b0;
      end
      else
      begin
        clkOut_q <= stopHigh;
      end
    end
  end

  // undivided rate has to pass clk itself; a registered copy cannot toggle that fast
  assign cardClk = (rate == 2'b11 && advance) ? clk : clkOut_q;

endmodule // card_clk_gen

`default_nettype wire

// ===== verilog/card_if_map.vh
`ifndef CARD_IF_MAP_VH
`define CARD_IF_MAP_VH

// serial slave address byte, read/write bit in bit 0
`define ADDR_BASE 8'h40

`define CTRL_RESET 8'h00
`define STAT_RESET 8'h04

// control register fields
`define CB_START 0
`define CB_WARM 1
`define CB_VCC3 2
`define CB_CLKSTOP 3
`define CB_STOPHIGH 4
`define CB_RATE_LO 5
`define CB_RATE_HI 6
`define CB_IOEN 7

// status register fields
`define SB_CARD_PRESENT 0
`define SB_PRESENCE_CHANGED 1
`define SB_IO 2
`define SB_SUPPLY_FAULT_LATCHED 3
`define SB_PROTECTION_FAULT_LATCHED 4
`define SB_MUTE 5
`define SB_EARLY 6
`define SB_ACTIVE 7

// timing
`define CLK_HZ 20000000
`define SCL_MAX_KHZ 400
`define PWR_SETTLE_NS 50000
`define DEACT_NS 10000
`define RST_LOW_CARD_CYC 500
`define MUTE_CARD_CYC 40000
`define EARLY_CARD_CYC 400
`define IO_GUARD_CYC 2'h3

`endif

// ===== verilog/card_interface_host_port.v
`timescale 1ns/1ps
`default_nettype none
`include "card_if_map.vh"

module card_interface_host_port #(
  parameter MUTE_CYC = `MUTE_CARD_CYC,
  parameter EARLY_CYC = `EARLY_CARD_CYC,
  parameter RST_LOW_CYC = `RST_LOW_CARD_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOeB,
  input wire [2:0] addrSelectPins,
  input wire cardPresent,
  input wire supplyFault,
  input wire protFault,
  input wire cardIoIn,
  output wire cardIoOut,
  output wire cardIoOeB,
  input wire hostSideDataLineIn,
  output wire hostSideDataLineOut,
  output wire hostSideDataLineOeB,
  output reg cardVccOn,
  output wire cardVcc3v,
  output reg cardRst,
  output wire cardClk,
  output reg intB
);

  localparam PWR_CYC = (`PWR_SETTLE_NS * (`CLK_HZ / 1000000) + 999) / 1000;
  localparam DEACT_CYC = (`DEACT_NS * (`CLK_HZ / 1000000) + 999) / 1000;

  // serial slave states
  localparam [6:0] I_IDLE = 7'h01;
  localparam [6:0] I_ADDR = 7'h02;
  localparam [6:0] I_ACKA = 7'h04;
  localparam [6:0] I_WR = 7'h08;
  localparam [6:0] I_ACKW = 7'h10;
  localparam [6:0] I_RD = 7'h20;
  localparam [6:0] I_ACKR = 7'h40;

  // card session states
  localparam [5:0] S_OFF = 6'h01;
  localparam [5:0] S_PWR = 6'h02;
  localparam [5:0] S_RSTL = 6'h04;
  localparam [5:0] S_ATR = 6'h08;
  localparam [5:0] S_ON = 6'h10;
  localparam [5:0] S_DEACT = 6'h20;

  // pin synchronisers; idle-high lines reset high so status starts at 0x04
  localparam [9:0] SYNC_INIT = 10'h00f;
  wire [9:0] rawIn;
  reg [9:0] sync1_q;
  reg [9:0] sync2_q;
  reg [3:0] prev_q;
  wire sclS;
  wire sdaS;
  wire ioS;
  wire hostS;
  wire presS;
  wire supS;
  wire protS;
  wire [2:0] selS;

  assign rawIn = {addrSelectPins, protFault, supplyFault, cardPresent,
                  hostSideDataLineIn, cardIoIn, sdaIn, sclIn};
  assign sclS = sync2_q[0];
  assign sdaS = sync2_q[1];
  assign ioS = sync2_q[2];
  assign hostS = sync2_q[3];
  assign presS = sync2_q[4];
  assign supS = sync2_q[5];
  assign protS = sync2_q[6];
  assign selS = sync2_q[9:7];

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= SYNC_INIT;
      sync2_q <= SYNC_INIT;
      prev_q <= 4'h7;
    end
    else
    begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
      prev_q <= {presS, ioS, sdaS, sclS};
    end
  end

  wire sclRise = sclS & ~prev_q[0];
  wire sclFall = ~sclS & prev_q[0];
  wire busStart = sclS & prev_q[0] & ~sdaS & prev_q[1];
  wire busStop = sclS & prev_q[0] & sdaS & ~prev_q[1];
  wire ioFall = ~ioS & prev_q[2];
  wire presEdge = presS ^ prev_q[3];

  reg [6:0] iState_q;
  reg [2:0] bitCnt_q;
  reg byteDone_q;
  reg [7:0] shift_q;
  reg readDir_q;
  reg sdaLow_q;
  reg [7:0] ctrl_q;
  reg wrStrobe;
  reg rdStrobe;
  wire [7:0] status;
  wire addrHit;

  assign addrHit = ({shift_q[7:1], 1'b0} == (`ADDR_BASE + {4'h0, selS, 1'b0}));

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      iState_q <= I_IDLE;
      bitCnt_q <= 3'h0;
      byteDone_q <= 1'b0;
      shift_q <= 8'h00;
      readDir_q <= 1'b0;
      sdaLow_q <= 1'b0;
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
    end
    else
    begin
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      if (busStop)
      begin
        iState_q <= I_IDLE;
        sdaLow_q <= 1'b0;
      end
      else if (busStart)
      begin
        iState_q <= I_ADDR;
        bitCnt_q <= 3'h0;
        byteDone_q <= 1'b0;
        sdaLow_q <= 1'b0;
      end
      else
      begin
        case (iState_q)
          I_ADDR, I_WR:
          begin
            if (sclRise && !byteDone_q)
            begin
              shift_q <= {shift_q[6:0], sdaS};
              bitCnt_q <= bitCnt_q + 3'h1;
              byteDone_q <= (bitCnt_q == 3'h7);
            end
            else if (sclFall && byteDone_q)
            begin
              byteDone_q <= 1'b0;
              if (iState_q == I_WR)
              begin
                iState_q <= I_ACKW;
                sdaLow_q <= 1'b1;
                wrStrobe <= 1'b1;
              end
              else if (addrHit)
              begin
                iState_q <= I_ACKA;
                readDir_q <= shift_q[0];
                sdaLow_q <= 1'b1;
              end
              else
              begin
                iState_q <= I_IDLE;
              end
            end
          end
          I_ACKA:
          begin
            if (sclFall)
            begin
              bitCnt_q <= 3'h0;
              if (readDir_q)
              begin
                iState_q <= I_RD;
                shift_q <= status;
                sdaLow_q <= ~status[7];
                rdStrobe <= 1'b1;
              end
              else
              begin
                iState_q <= I_WR;
                sdaLow_q <= 1'b0;
              end
            end
          end
          I_ACKW:
          begin
            // one control byte per frame; anything after waits for the next START
            if (sclFall)
            begin
              iState_q <= I_IDLE;
              sdaLow_q <= 1'b0;
            end
          end
          I_RD:
          begin
            if (sclFall)
            begin
              bitCnt_q <= bitCnt_q + 3'h1;
              shift_q <= {shift_q[6:0], 1'b1};
              if (bitCnt_q == 3'h7)
              begin
                iState_q <= I_ACKR;
                sdaLow_q <= 1'b0;
              end
              else
              begin
                sdaLow_q <= ~shift_q[6];
              end
            end
          end
          I_ACKR:
          begin
            if (sclFall)
            begin
              iState_q <= I_IDLE;
            end
          end
          default:
          begin
            iState_q <= I_IDLE;
          end
        endcase
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOeB = ~sdaLow_q;

  // card session sequencer
  reg [5:0] sState_q;
  reg [15:0] wait_q;
  reg answered;
  reg muteHit;
  reg [7:0] latch_q;
  reg presence_changed_q;
  reg supply_fault_latched_q;
  reg protection_fault_latched_q;
  reg mute_q;
  reg early_q;
  wire cardTick;
  wire startReq = wrStrobe & shift_q[`CB_START] & ~ctrl_q[`CB_START];
  wire stopReq = wrStrobe & ~shift_q[`CB_START] & ctrl_q[`CB_START];
  wire warmReq = wrStrobe & shift_q[`CB_WARM];
  wire inSession = ~sState_q[0] & ~sState_q[5];
  wire abort = ~presS | supS | protS | stopReq;
  wire clearWarm = answered | muteHit | (ctrl_q[`CB_WARM] & ~sState_q[3] & ~sState_q[2]);

  always @*
  begin
    answered = sState_q[3] & ioFall;
    muteHit = sState_q[3] & cardTick & (wait_q == MUTE_CYC - 1);
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= `CTRL_RESET;
    end
    else if (wrStrobe)
    begin
      ctrl_q <= shift_q;
    end
    else if (clearWarm)
    begin
      ctrl_q[`CB_WARM] <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sState_q <= S_OFF;
      wait_q <= 16'h0000;
      cardVccOn <= 1'b0;
      cardRst <= 1'b0;
    end
    else
    begin
      case (sState_q)
        S_OFF:
        begin
          if (startReq && presS && !supS && !protS)
          begin
            sState_q <= S_PWR;
            cardVccOn <= 1'b1;
            wait_q <= 16'h0000;
          end
        end
        S_PWR:
        begin
          wait_q <= wait_q + 16'h0001;
          if (wait_q == PWR_CYC - 1)
          begin
            sState_q <= S_RSTL;
            wait_q <= 16'h0000;
          end
        end
        S_RSTL:
        begin
          cardRst <= 1'b0;
          if (cardTick)
          begin
            wait_q <= wait_q + 16'h0001;
          end
          if (cardTick && wait_q == RST_LOW_CYC - 1)
          begin
            sState_q <= S_ATR;
            cardRst <= 1'b1;
            wait_q <= 16'h0000;
          end
        end
        S_ATR:
        begin
          if (cardTick)
          begin
            wait_q <= wait_q + 16'h0001;
          end
          if (answered || muteHit)
          begin
            sState_q <= S_ON;
          end
        end
        S_ON:
        begin
          if (warmReq)
          begin
            sState_q <= S_RSTL;
            cardRst <= 1'b0;
            wait_q <= 16'h0000;
          end
        end
        S_DEACT:
        begin
          wait_q <= wait_q + 16'h0001;
          if (wait_q == DEACT_CYC - 1)
          begin
            sState_q <= S_OFF;
            cardVccOn <= 1'b0;
          end
        end
        default:
        begin
          sState_q <= S_OFF;
        end
      endcase
      // removal, fault or a cleared start bit forces deactivation
      if (inSession && abort)
      begin
        sState_q <= S_DEACT;
        cardRst <= 1'b0;
        wait_q <= 16'h0000;
      end
    end
  end

  // 3 V select follows the register; host keeps it through deactivation
  assign cardVcc3v = ctrl_q[`CB_VCC3];

  card_clk_gen card_clk_gen_i (
    .clk(clk),
    .rst_b(rst_b),
    .run(sState_q[2] | sState_q[3] | sState_q[4]),
    .stop(sState_q[4] & ctrl_q[`CB_CLKSTOP]),
    .stopHigh(ctrl_q[`CB_STOPHIGH]),
    .rate({ctrl_q[`CB_RATE_HI], ctrl_q[`CB_RATE_LO]}),
    .cardClk(cardClk),
    .tick(cardTick)
  );

  // status latches: a new event beats a read clear in the same cycle
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      presence_changed_q <= 1'b0;
      supply_fault_latched_q <= 1'b0;
      protection_fault_latched_q <= 1'b0;
      mute_q <= 1'b0;
      early_q <= 1'b0;
      intB <= 1'b1;
    end
    else
    begin
      presence_changed_q <= presEdge | (presence_changed_q & ~rdStrobe);
      supply_fault_latched_q <= supS | (supply_fault_latched_q & ~rdStrobe);
      protection_fault_latched_q <= (protS & inSession) | (protection_fault_latched_q & ~rdStrobe);
      if (sState_q[0] && startReq)
      begin
        mute_q <= 1'b0;
        early_q <= 1'b0;
      end
      else
      begin
        mute_q <= mute_q | muteHit;
        early_q <= early_q | (answered & (wait_q < EARLY_CYC));
      end
      intB <= ~((presEdge | presence_changed_q) | (supS | supply_fault_latched_q) | (protS & inSession) | protection_fault_latched_q);
    end
  end

  always @*
  begin
    latch_q = 8'h00;
    latch_q[`SB_CARD_PRESENT] = presS;
    latch_q[`SB_PRESENCE_CHANGED] = presence_changed_q;
    latch_q[`SB_IO] = ioS;
    latch_q[`SB_SUPPLY_FAULT_LATCHED] = supply_fault_latched_q;
    latch_q[`SB_PROTECTION_FAULT_LATCHED] = protection_fault_latched_q;
    latch_q[`SB_MUTE] = mute_q;
    latch_q[`SB_EARLY] = early_q;
    latch_q[`SB_ACTIVE] = cardVccOn;
  end
  assign status = latch_q;

  // data line relay: whichever side went low first owns it; a short guard
  // after release stops our own drive echoing back through the synchronisers
  reg [1:0] owner_q;
  reg [1:0] guard_q;
  wire relayOn = ctrl_q[`CB_IOEN] & (sState_q[3] | sState_q[4]);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      owner_q <= 2'h0;
      guard_q <= 2'h0;
    end
    else if (!relayOn)
    begin
      owner_q <= 2'h0;
      guard_q <= 2'h0;
    end
    else if (owner_q == 2'h1 && ioS)
    begin
      owner_q <= 2'h0;
      guard_q <= `IO_GUARD_CYC;
    end
    else if (owner_q == 2'h2 && hostS)
    begin
      owner_q <= 2'h0;
      guard_q <= `IO_GUARD_CYC;
    end
    else if (guard_q != 2'h0)
    begin
      guard_q <= guard_q - 2'h1;
    end
    else if (owner_q == 2'h0 && !ioS)
    begin
      owner_q <= 2'h1;
    end
    else if (owner_q == 2'h0 && !hostS)
    begin
      owner_q <= 2'h2;
    end
  end

  assign hostSideDataLineOut = 1'b0;
  assign hostSideDataLineOeB = ~(owner_q == 2'h1);
  assign cardIoOut = 1'b0;
  // contact pulled low while shutting down or while relaying a host-side low; left to its pull-up when off
  assign cardIoOeB = ~((owner_q == 2'h2) | sState_q[5]);

endmodule // card_interface_host_port

`default_nettype wire
